// ==== logic/pcl_core.sv ====
// program counter load logic with return stack and clock output
//
// Behaviour
// - 13-bit counter, low byte software readable/writable
// - upper five bits load only via latch, operand, stack or interrupt vector
// - any reset clears the whole counter
// - low-byte write loads upper from latch[4:0]
// - call/goto loads bits 12:11 from latch[4:3]
// - adding offset to low byte jumps; no carry
// - clock output at quarter oscillator rate
// - master clear low resets the device
// - eight-entry circular stack, push/pop on call/return
// - stack leaves latch alone, no overflow flags
`timescale 1ns/1ps
module pcl_core
    import pcl_pkg::*;
(
    // clock and resets
    input wire logic clk,
    input wire logic rst,
    input wire logic master_clear_n,
    // oscillator input from pin
    input wire logic oscillator_input,
    // decoder requests
    input wire pcl_op_t op,
    input wire pcl_arg_t arg,
    // counter outputs
    output logic [12:0] pc,
    output logic [7:0] pc_low_byte_reg,
    output logic [7:0] pc_high_latch,
    output logic ret_ready,
    // clock output pin
    output logic instr_cycle_clock_out
);
    // pipeline state: idle, or waiting for the popped address
    typedef enum logic [1:0] {
        ST_RUN = 2'b01,
        ST_POP = 2'b10
    } pcl_state_t;

    // operation decoding used once, for the stack write enable: push request
    function automatic logic is_push(input pcl_op_t o);
        return o.call | o.irq_entry;
    endfunction

    // synchroniser, sequencing registers and their next values
    logic [2:0] master_clear_n_sync;
    logic [2:0] next_master_clear_n_sync;
    logic master_clear_n_level;
    logic next_master_clear_n_level;
    logic reset_all;
    logic [12:0] next_pc;
    logic [7:0] next_latch;
    logic [2:0] sp;
    logic [2:0] next_sp;
    pcl_state_t state;
    pcl_state_t next_state;
    logic next_ret_ready;
    logic [12:0] stack_rd;
    logic [2:0] rd_ptr;
    logic [7:0] sum_low;

    // master clear stages shift; filtered level moves once the late stages agree
    always_comb begin
        next_master_clear_n_sync = {master_clear_n_sync[1:0], master_clear_n};
        next_master_clear_n_level = (master_clear_n_sync[2] == master_clear_n_sync[1]) ? master_clear_n_sync[2] : master_clear_n_level;
    end

    // master clear pin synchronised through three stages
    // stages start at the idle high level so rst leaves no false clear behind
    always_ff @(posedge clk) begin
        if (rst) begin
            master_clear_n_sync <= 3'h7;
            master_clear_n_level <= 1'b1;
        end else begin
            master_clear_n_sync <= next_master_clear_n_sync;
            master_clear_n_level <= next_master_clear_n_level;
        end
    end

    // reset asserts when the late stages agree low, holds until they agree high
    assign reset_all = rst | ~next_master_clear_n_level;

    // stack read address: top of stack is one below pointer
    assign rd_ptr = sp - 3'h1;
    // computed jump: carry out of the low byte is dropped, page stays from latch
    assign sum_low = pc[7:0] + arg.data;

    // push only when the push branch wins; a return in the same slot has priority
    // registered read: popped address is ready one cycle after the return
    pcl_stack_mem #(
        .DEPTH(STACK_DEPTH),
        .AW(STACK_PTR_W),
        .DW(PC_W)
    ) u_stack (
        .clk(clk),
        .wr_en(is_push(op) && !op.ret && state == ST_RUN && !reset_all),
        .wr_addr(sp),
        .wr_data(pc),
        .rd_addr(rd_ptr),
        .rd_data(stack_rd)
    );

    // next counter, latch, pointer and state
    always_comb begin
        next_pc = pc;
        next_latch = pc_high_latch;
        next_sp = sp;
        next_state = state;
        next_ret_ready = 1'b0;
        case (state)
            ST_RUN: begin
                // latch write combines with any operation; loads see the old latch
                if (op.latch_write) begin
                    next_latch = arg.data;
                end
                // priority: return, interrupt, call or goto, low write, add
                if (op.ret) begin
                    next_state = ST_POP;
                end else if (op.irq_entry) begin
                    next_sp = sp + 3'h1;
                    next_pc = arg.vector;
                end else if (op.call || op.jump) begin
                    if (op.call) begin
                        next_sp = sp + 3'h1;
                    end
                    next_pc = {pc_high_latch[LATCH_PAGE_LSB +: 2], arg.operand};
                end else if (op.write_low) begin
                    next_pc = {pc_high_latch[LATCH_UPPER_LSB +: UPPER_W], arg.data};
                end else if (op.add_low) begin
                    next_pc = {pc_high_latch[LATCH_UPPER_LSB +: UPPER_W], sum_low};
                end
            end
            ST_POP: begin
                // pointer wraps silently, latch untouched
                next_pc = stack_rd;
                next_sp = rd_ptr;
                next_ret_ready = 1'b1;
                next_state = ST_RUN;
            end
            default: begin
                next_state = ST_RUN;
            end
        endcase
    end

    // counter, latch and stack pointer registers
    always_ff @(posedge clk) begin
        if (reset_all) begin
            pc <= PC_RESET;
            pc_high_latch <= LATCH_RESET;
            sp <= SP_RESET;
            state <= ST_RUN;
            ret_ready <= 1'b0;
        end else begin
            pc <= next_pc;
            pc_high_latch <= next_latch;
            sp <= next_sp;
            state <= next_state;
            ret_ready <= next_ret_ready;
        end
    end

    // low-byte view mirrors counter bits 7:0
    always_ff @(posedge clk) begin
        if (reset_all) begin
            pc_low_byte_reg <= PC_RESET[7:0];
        end else begin
            pc_low_byte_reg <= next_pc[7:0];
        end
    end

    // oscillator input sampled through three stages
    logic [2:0] osc_sync;
    logic [2:0] next_osc_sync;
    logic osc_level;
    logic osc_prev;
    logic [1:0] osc_cnt;
    logic [1:0] next_osc_cnt;
    logic next_clk_out;
    logic next_osc_level;

    // oscillator stages, cleared by rst only
    always_ff @(posedge clk) begin
        if (rst) begin
            osc_sync <= 3'h0;
        end else begin
            osc_sync <= next_osc_sync;
        end
    end

    // filtered level, edge count, divided clock
    always_comb begin
        next_osc_sync = {osc_sync[1:0], oscillator_input};
        next_osc_level = (osc_sync[2] == osc_sync[1]) ? osc_sync[2] : osc_level;
        next_osc_cnt = osc_cnt;
        next_clk_out = instr_cycle_clock_out;
        if (osc_level && !osc_prev) begin
            if (osc_cnt == 2'(OSC_HALF - 1)) begin
                next_osc_cnt = 2'h0;
                next_clk_out = ~instr_cycle_clock_out;
            end else begin
                next_osc_cnt = osc_cnt + 2'h1;
            end
        end
    end

    // filtered level, edge history, counter and clock out registers
    always_ff @(posedge clk) begin
        if (reset_all) begin
            osc_level <= 1'b0;
            osc_prev <= 1'b0;
            osc_cnt <= 2'h0;
            instr_cycle_clock_out <= 1'b0;
        end else begin
            osc_level <= next_osc_level;
            osc_prev <= osc_level;
            osc_cnt <= next_osc_cnt;
            instr_cycle_clock_out <= next_clk_out;
        end
    end
endmodule

// ==== logic/pcl_pkg.sv ====
// package: constants and carrier types for the program counter load logic
package pcl_pkg;
    localparam int PC_W = 13;
    localparam int LOW_W = 8;
    localparam int UPPER_W = 5;
    localparam int LATCH_W = 8;
    localparam int OPER_W = 11;
    localparam int STACK_DEPTH = 8;
    localparam int STACK_PTR_W = 3;
    // field positions
    localparam int LATCH_UPPER_LSB = 0;
    localparam int LATCH_PAGE_LSB = 3;
    // reset values
    localparam logic [12:0] PC_RESET = 13'h0000;
    localparam logic [7:0] LATCH_RESET = 8'h00;
    localparam logic [2:0] SP_RESET = 3'h0;
    // clock out divides the oscillator input by this ratio
    localparam int OSC_DIV = 4;
    localparam int OSC_HALF = OSC_DIV / 2;

    // sequencing operation requested by the instruction decoder
    typedef struct packed {
        logic write_low;          // instruction writes the low-byte register
        logic add_low;            // add_accumulator_to_file on the low byte
        logic jump;               // goto
        logic call;               // call: push then jump
        logic irq_entry;          // interrupt vectoring: push then vector
        logic ret;                // return, return_with_literal, return_from_interrupt
        logic latch_write;        // write of pc_high_latch
    } pcl_op_t;

    // data accompanying an operation
    typedef struct packed {
        logic [7:0] data;         // write value or addend
        logic [10:0] operand;     // 11-bit address operand
        logic [12:0] vector;      // interrupt vector address
    } pcl_arg_t;
endpackage

// ==== logic/pcl_stack_mem.sv ====
// return-address stack storage, registered read
`timescale 1ns/1ps
module pcl_stack_mem
    import pcl_pkg::*;
#(
    parameter int DEPTH = STACK_DEPTH,
    parameter int AW = STACK_PTR_W,
    parameter int DW = PC_W
) (
    // clock
    input wire logic clk,
    // write port
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [DW-1:0] wr_data,
    // read port
    input wire logic [AW-1:0] rd_addr,
    output logic [DW-1:0] rd_data
);
    logic [DW-1:0] mem [DEPTH];

    // storage write and registered read
    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule

// ==== test/pcl_chk.sv ====
// checker: counter load relations at the core ports
`timescale 1ns/1ps
module pcl_chk
    import pcl_pkg::*;
(
    // inputs
    input wire logic clk,
    input wire logic rst,
    input wire logic master_clear_n,
    input wire pcl_op_t op,
    input wire pcl_arg_t arg,
    // outputs
    input wire logic [12:0] pc,
    input wire logic [7:0] pc_low_byte_reg,
    input wire logic [7:0] pc_high_latch,
    input wire logic ret_ready
);
    logic [3:0] mh;
    logic pr;
    logic ok;
    // clear pin history, pop slot
    always_ff @(posedge clk) begin
        mh <= {mh[2:0], master_clear_n};
        pr <= op.ret;
    end
    assign ok = master_clear_n && (&mh) && !pr;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    property p_mir; pc_low_byte_reg == pc[7:0]; endproperty
    a_mir: assert property (p_mir) else $error("low byte");
    property p_clr; disable iff (1'b0) rst |=> pc == 13'h0000 && pc_high_latch == 8'h00; endproperty
    a_clr: assert property (p_clr) else $error("reset");
    property p_wr; op.write_low && !(op.ret|op.irq_entry|op.call|op.jump) && ok
        |=> pc == {$past(pc_high_latch[4:0]), $past(arg.data)}; endproperty
    a_wr: assert property (p_wr) else $error("low write");
    property p_add; op.add_low && !(op.ret|op.irq_entry|op.call|op.jump|op.write_low) && ok
        |=> pc == {$past(pc_high_latch[4:0]), 8'($past(pc[7:0]) + $past(arg.data))}; endproperty
    a_add: assert property (p_add) else $error("add");
    property p_go; (op.call|op.jump) && !(op.ret|op.irq_entry) && ok
        |=> pc == {$past(pc_high_latch[4:3]), $past(arg.operand)}; endproperty
    a_go: assert property (p_go) else $error("goto");
    property p_ret; op.ret && ok |=> !ret_ready ##1 ret_ready ##1 !ret_ready; endproperty
    a_ret: assert property (p_ret) else $error("pop");
    property p_lat; !op.latch_write && ok |=> $stable(pc_high_latch); endproperty
    a_lat: assert property (p_lat) else $error("latch");
    property p_hold; op == '0 && ok |=> $stable(pc); endproperty
    a_hold: assert property (p_hold) else $error("hold");
    property p_mc; !master_clear_n [*4] |=> pc == 13'h0000; endproperty
    a_mc: assert property (p_mc) else $error("clear pin");
    c_ret: cover property (op.ret && ok ##2 ret_ready);
    c_add: cover property (op == 7'h20 && ok);
    c_mc: cover property (!master_clear_n [*4]);
endmodule
bind pcl_core pcl_chk u_chk (.clk, .rst, .master_clear_n, .op, .arg, .pc,
    .pc_low_byte_reg, .pc_high_latch, .ret_ready);

// ==== test/pcl_dec_model.sv ====
// decoder model: one request a cycle, pop slot left idle
`timescale 1ns/1ps
module pcl_dec_model
    import pcl_pkg::*;
(
    // clock
    input wire logic clk,
    // requests
    output pcl_op_t op,
    output pcl_arg_t arg
);
    initial begin
        op = '0;
        arg = '0;
    end
    // one request; a return is followed by an idle slot
    task automatic send(input pcl_op_t o, input pcl_arg_t a);
        op = o;
        arg = a;
        @(negedge clk);
        if (o.ret) begin
            op = '0;
            arg = ~a;
            @(negedge clk);
        end
    endtask
    task automatic idle();
        op = '0;
        arg = ~arg;
    endtask
endmodule

// ==== test/program_counter_load_logic_test.sv ====
// testbench: counter load logic against a bench model
`timescale 1ns/1ps
module program_counter_load_logic_test
    import pcl_pkg::*;
;
    logic clk, rst, master_clear_n, oscillator_input, ret_ready, ck_out;
    pcl_op_t op, o;
    pcl_arg_t arg, a;
    logic [12:0] pc, m_pc;
    logic [12:0] stk [8];
    logic [7:0] lat, m_lat, old, pcl;
    int seed = 99753;
    int sp, mismatches, tests_run, cycles, edges;
    pcl_core uut (.clk, .rst, .master_clear_n, .oscillator_input, .op, .arg, .pc,
        .pc_low_byte_reg(pcl), .pc_high_latch(lat), .ret_ready, .instr_cycle_clock_out(ck_out));
    pcl_dec_model dec (.clk, .op, .arg);
    // clocks, timeout, clock out edges
    initial begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    initial begin
        oscillator_input = 0;
        forever begin
            repeat (4) @(negedge clk);
            oscillator_input = ~oscillator_input;
        end
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            end_of_test();
        end
    end
    always @(posedge ck_out) edges++;
    task automatic chk(input string n, input logic [12:0] e, input logic [12:0] g);
        tests_run++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // reset by rst or by the clear pin
    task automatic do_reset(input logic pin);
        if (pin) master_clear_n = 0;
        else rst = 1;
        repeat (8) @(posedge clk);
        @(negedge clk);
        master_clear_n = 1;
        rst = 0;
        repeat (4) @(negedge clk);
        m_pc = 0;
        m_lat = 0;
        sp = 0;
        chk("pc", 0, pc);
        chk("latch", 0, lat);
    endtask
    // model one request, send it, compare
    task automatic step();
        old = m_lat;
        if (o.latch_write) m_lat = a.data;
        if (o.ret) begin
            sp = (sp + 7) % 8;
            m_pc = stk[sp];
        end else if (o.irq_entry || o.call) begin
            stk[sp] = m_pc;
            sp = (sp + 1) % 8;
            m_pc = o.irq_entry ? a.vector : {old[4:3], a.operand};
        end else if (o.jump) m_pc = {old[4:3], a.operand};
        else if (o.write_low) m_pc = {old[4:0], a.data};
        else if (o.add_low) m_pc = {old[4:0], m_pc[7:0] + a.data};
        dec.send(o, a);
        chk("pc", m_pc, pc);
        chk("low byte", 13'(m_pc[7:0]), 13'(pcl));
        chk("latch", m_lat, lat);
        if (o.ret) chk("ret_ready", 1, ret_ready);
    endtask
    initial begin
        rst = 1;
        master_clear_n = 1;
        do_reset(0);
        $display("test reset done");
        for (int i = 0; i < 20; i++) begin
            a = $random(seed);
            o = '0;
            o.call = i < 10;
            o.ret = i >= 10;
            step();
        end
        $display("test stack wrap done");
        for (int i = 0; i < 300; i++) begin
            a = $random(seed);
            o = 7'($random(seed));
            step();
        end
        dec.idle();
        $display("test random ops done");
        edges = 0;
        repeat (320) @(negedge clk);
        chk("clock out edges", 10, 13'(edges));
        $display("test clock out done");
        do_reset(1);
        $display("test clear pin done");
        end_of_test();
    end
endmodule
